// *** rtl/spi_host_pkg.sv ***
// Constants shared by the daisy-chain serial port controller and its byte shifter
package spi_host_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SCLK_PERIOD_NS = 160;
  // Half serial period in system cycles, rounded down, never below one
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 : SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned BYTE_BITS = 8;

  // ----------------------------------------------------------------
  // Local register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_REG = 2;
  localparam int unsigned CTRL_BCAST = 3;
  localparam int unsigned CTRL_WIDE = 4;
  localparam int unsigned CTRL_CID_LO = 8;

  // Status register fields
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_BCRD_ERR = 2;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_CONTROL = 2'h0;
  localparam logic [1:0] IDX_ADDRESS = 2'h1;
  localparam logic [1:0] IDX_DATA_HI = 2'h2;
  localparam logic [1:0] IDX_DATA_LO = 2'h3;
  localparam logic [1:0] LAST_IDX_SHORT = 2'h2;
  localparam logic [1:0] LAST_IDX_LONG = 2'h3;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic RESERVED_BIT = 1'b0;

endpackage

// *** rtl/shift_if.sv ***
// Byte transfer handshake between the frame sequencer and the byte shifter
`timescale 1ns/100ps
interface shift_if;
  logic start;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic done;
  logic miso_s;
  logic sclk;
  logic mosi;

  modport seq
  (
    output start,
    output tx_byte,
    output miso_s,
    input rx_byte,
    input done,
    input sclk,
    input mosi
  );

  modport shifter
  (
    input start,
    input tx_byte,
    input miso_s,
    output rx_byte,
    output done,
    output sclk,
    output mosi
  );
endinterface

// *** rtl/spi_byte_shifter.sv ***
// Shifts one byte out and in with eight return-to-one serial clock cycles
`timescale 1ns/100ps
module spi_byte_shifter
  import spi_host_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  shift_if.shifter sh
);

  typedef struct packed {
    logic busy;
    logic high;
    logic [7:0] cnt;
    logic [2:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sclk;
    logic mosi;
    logic done;
  } shf_state_t;

  shf_state_t s_q;
  shf_state_t s_d;

  // ----------------------------------------------------------------
  // Bit sequencing
  // ----------------------------------------------------------------
  // Output changes on the falling edge, input is taken on the rising one
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy)
    begin
      if (sh.start)
      begin
        s_d.busy = 1'b1;
        s_d.high = 1'b0;
        s_d.cnt = 8'h00;
        s_d.bitn = 3'h0;
        s_d.sclk = 1'b0;
        s_d.mosi = sh.tx_byte[7];
        s_d.tx = {sh.tx_byte[6:0], 1'b0};
      end
    end
    else if (s_q.cnt == 8'(HALF_CYC - 1))
    begin
      s_d.cnt = 8'h00;
      if (!s_q.high)
      begin
        s_d.sclk = 1'b1;
        s_d.high = 1'b1;
        s_d.rx = {s_q.rx[6:0], sh.miso_s};
      end
      else if (s_q.bitn == 3'(BYTE_BITS - 1))
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.sclk = 1'b0;
        s_d.high = 1'b0;
        s_d.mosi = s_q.tx[7];
        s_d.tx = {s_q.tx[6:0], 1'b0};
        s_d.bitn = s_q.bitn + 3'h1;
      end
    end
    else
    begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // State register; the clock rests high out of reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '{busy: 1'b0, high: 1'b0, cnt: 8'h00, bitn: 3'h0, tx: 8'h00, rx: 8'h00,
               sclk: 1'b1, mosi: 1'b0, done: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sh.sclk = s_q.sclk;
  assign sh.mosi = s_q.mosi;
  assign sh.rx_byte = s_q.rx;
  assign sh.done = s_q.done;

endmodule

// *** rtl/spi_daisy_host.sv ***
// Controller for a chain of dual-channel line interface devices on a serial control port
//
// Operation
// - Control, address (seven bits), one/two data
// - Every byte shifted msb first
// - Select low before first fall, whole byte
// - Eight clocks per byte, clock idles high
// - Shared data line needs host release
// - Control: broadcast, read, register, reserved, channel
// - Read=1 write=0; register=1 RAM=0
// - Broadcast only allowed for writes
// - Channel identifier field sent lsb first
// - Narrow register access is three bytes
// - Narrow mode: select toggles between bytes
// - Wide register access four bytes, data repeats; host sends filler as second write data byte
// - RAM accesses always span four bytes
`timescale 1ns/100ps
module spi_daisy_host
  import spi_host_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic spi_mosi_oe,
  input wire logic spi_miso
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_BYTE,
    ST_GAP
  } seq_state_t;

  typedef struct packed {
    logic rd;
    logic reg_sel;
    logic bcast;
    logic wide;
    logic [3:0] channel_id;
    logic [6:0] addr;
    logic [15:0] wdata;
  } cfg_t;

  typedef struct packed {
    seq_state_t st;
    cfg_t cfg;
    logic [15:0] rdata;
    logic busy;
    logic done;
    logic bcrd_err;
    logic [1:0] idx;
    logic [7:0] cnt;
    logic start;
    logic [7:0] tx;
    logic cs_n;
    logic mosi_oe;
    logic miso_m;
    logic miso_s;
    logic [31:0] bus_rdata;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;

  shift_if sh ();

  // ----------------------------------------------------------------
  // Frame helpers
  // ----------------------------------------------------------------
  // Byte to send at a given position of the frame
  function automatic logic [7:0] frame_byte(input cfg_t c, input logic [1:0] idx);
    logic [7:0] b;
    b = FILL_BYTE;
    unique case (idx)
      IDX_CONTROL:
      begin
        // identifier reversed so its lsb leads
        b = {c.bcast, c.rd, c.reg_sel, RESERVED_BIT, c.channel_id[0], c.channel_id[1], c.channel_id[2], c.channel_id[3]};
      end
      IDX_ADDRESS:
      begin
        b = {1'b0, c.addr};
      end
      IDX_DATA_HI:
      begin
        // RAM word sent high byte first
        b = c.reg_sel ? c.wdata[7:0] : c.wdata[15:8];
      end
      IDX_DATA_LO:
      begin
        // second register byte is ignored filler
        b = c.reg_sel ? FILL_BYTE : c.wdata[7:0];
      end
    endcase
    return b;
  endfunction

  // Position of the final byte of the frame
  function automatic logic [1:0] last_idx(input cfg_t c);
    // narrow register access ends after three bytes
    return (c.reg_sel && !c.wide) ? LAST_IDX_SHORT : LAST_IDX_LONG;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer, register port and input synchroniser
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.bus_rdata = 32'h0000_0000;
    // Serial input crosses in from the pin through two stages
    s_d.miso_m = spi_miso;
    s_d.miso_s = s_q.miso_m;

    // Register reads: data stand for exactly one cycle
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CTRL:
        begin
          s_d.bus_rdata[CTRL_READ] = s_q.cfg.rd;
          s_d.bus_rdata[CTRL_REG] = s_q.cfg.reg_sel;
          s_d.bus_rdata[CTRL_BCAST] = s_q.cfg.bcast;
          s_d.bus_rdata[CTRL_WIDE] = s_q.cfg.wide;
          s_d.bus_rdata[CTRL_CID_LO +: 4] = s_q.cfg.channel_id;
        end
        OFS_ADDR: s_d.bus_rdata[6:0] = s_q.cfg.addr;
        OFS_WDATA: s_d.bus_rdata[15:0] = s_q.cfg.wdata;
        OFS_RDATA: s_d.bus_rdata[15:0] = s_q.rdata;
        OFS_STATUS:
        begin
          s_d.bus_rdata[STAT_BUSY] = s_q.busy;
          s_d.bus_rdata[STAT_DONE] = s_q.done;
          s_d.bus_rdata[STAT_BCRD_ERR] = s_q.bcrd_err;
        end
        default: s_d.bus_rdata = 32'h0000_0000;
      endcase
    end

    // Register writes; settings are frozen while a frame runs
    if (reg_wr && !s_q.busy)
    begin
      unique case (reg_addr)
        OFS_CTRL:
        begin
          s_d.cfg.rd = reg_wdata[CTRL_READ];
          s_d.cfg.reg_sel = reg_wdata[CTRL_REG];
          s_d.cfg.bcast = reg_wdata[CTRL_BCAST];
          s_d.cfg.wide = reg_wdata[CTRL_WIDE];
          // channel = two per device plus channel within device
          // host sends the channel number, chain counts it down
          s_d.cfg.channel_id = reg_wdata[CTRL_CID_LO +: 4];
          if (reg_wdata[CTRL_START])
          begin
            // broadcast read refused, no frame sent
            if (reg_wdata[CTRL_BCAST] && reg_wdata[CTRL_READ])
            begin
              s_d.bcrd_err = 1'b1;
            end
            else
            begin
              s_d.busy = 1'b1;
              s_d.done = 1'b0;
              s_d.idx = IDX_CONTROL;
              s_d.cnt = 8'h00;
              s_d.cs_n = 1'b0;
              s_d.st = ST_SETUP;
            end
          end
        end
        OFS_ADDR: s_d.cfg.addr = reg_wdata[6:0];
        OFS_WDATA: s_d.cfg.wdata = reg_wdata[15:0];
        default:
        begin
        end
      endcase
    end

    // Sticky flags cleared by writing one; a set later in this process wins
    if (reg_wr && reg_addr == OFS_STATUS)
    begin
      if (reg_wdata[STAT_DONE])
      begin
        s_d.done = 1'b0;
      end
      if (reg_wdata[STAT_BCRD_ERR])
      begin
        s_d.bcrd_err = 1'b0;
      end
    end

    unique case (s_q.st)
      ST_IDLE:
      begin
      end
      ST_SETUP:
      begin
        // select settles half a period plus one cycle before the first fall
        if (s_q.cnt == 8'(HALF_CYC - 1))
        begin
          s_d.cnt = 8'h00;
          s_d.start = 1'b1;
          s_d.tx = frame_byte(s_q.cfg, s_q.idx);
          // release the data line during read data
          s_d.mosi_oe = !(s_q.cfg.rd && s_q.idx >= IDX_DATA_HI);
          s_d.st = ST_BYTE;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      ST_BYTE:
      begin
        if (sh.done)
        begin
          // RAM read returns the word queued by the prior read
          if (s_q.cfg.rd && s_q.idx == IDX_DATA_HI)
          begin
            s_d.rdata = s_q.cfg.reg_sel ? {8'h00, sh.rx_byte} : {sh.rx_byte, s_q.rdata[7:0]};
          end
          // repeated register byte is not stored
          if (s_q.cfg.rd && !s_q.cfg.reg_sel && s_q.idx == IDX_DATA_LO)
          begin
            s_d.rdata = {s_q.rdata[15:8], sh.rx_byte};
          end
          if (s_q.idx == last_idx(s_q.cfg))
          begin
            // release after the last rising edge
            s_d.cs_n = 1'b1;
            s_d.mosi_oe = 1'b1;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
          else if (!s_q.cfg.wide || s_q.idx[0])
          begin
            // narrow mode toggles select between bytes
            // wide mode toggles only between 16-bit words
            s_d.cs_n = 1'b1;
            s_d.idx = s_q.idx + 2'h1;
            s_d.cnt = 8'h00;
            s_d.st = ST_GAP;
          end
          else
          begin
            // select held low so eight more clocks follow
            s_d.idx = s_q.idx + 2'h1;
            s_d.start = 1'b1;
            s_d.tx = frame_byte(s_q.cfg, s_q.idx + 2'h1);
            s_d.mosi_oe = !(s_q.cfg.rd && (s_q.idx + 2'h1) >= IDX_DATA_HI);
          end
        end
      end
      ST_GAP:
      begin
        // Select high for half a period, clock resting high
        if (s_q.cnt == 8'(HALF_CYC - 1))
        begin
          s_d.cnt = 8'h00;
          s_d.cs_n = 1'b0;
          s_d.st = ST_SETUP;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
    endcase
  end

  // State register with constant reset values only
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '{st: ST_IDLE, cfg: '0, rdata: 16'h0000, busy: 1'b0, done: 1'b0,
               bcrd_err: 1'b0, idx: 2'h0, cnt: 8'h00, start: 1'b0, tx: 8'h00,
               cs_n: 1'b1, mosi_oe: 1'b1, miso_m: 1'b0, miso_s: 1'b0,
               bus_rdata: 32'h0000_0000};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Byte shifter and outputs
  // ----------------------------------------------------------------
  assign sh.start = s_q.start;
  assign sh.tx_byte = s_q.tx;
  // Only the second synchroniser stage feeds the shifter
  assign sh.miso_s = s_q.miso_s;

  spi_byte_shifter #(
    .HALF_CYC(HALF_CYC)
  ) u_shifter (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sh(sh)
  );

  // All outputs come straight from flip-flops
  assign reg_rdata = s_q.bus_rdata;
  assign spi_cs_n = s_q.cs_n;
  assign spi_mosi_oe = s_q.mosi_oe;
  assign spi_sclk = sh.sclk;
  assign spi_mosi = sh.mosi;

endmodule

// *** tb/spi_daisy_host_chk.sv ***
// Serial port timing checker for the daisy-chain controller
`timescale 1ns/100ps
module spi_daisy_host_chk
  import spi_host_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_mosi_oe,
  input wire logic spi_miso
);
  logic [2:0] rise_cnt_q;
  logic go;
  logic bc_rd;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Start request and the refused broadcast read
  assign go = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START];
  assign bc_rd = reg_wdata[CTRL_READ] && reg_wdata[CTRL_BCAST];
  // Clock rises in one select window, modulo a byte
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rise_cnt_q <= 3'h0;
    else if (spi_cs_n)
      rise_cnt_q <= 3'h0;
    else if ($rose(spi_sclk))
      rise_cnt_q <= rise_cnt_q + 3'h1;
  end
  // Half periods assume the default divider of four
  sclk_idle_a: assert property (spi_cs_n |-> spi_sclk)
    else $error("clock low while idle");
  cs_setup_a: assert property ($fell(spi_sclk) |-> !spi_cs_n && !$past(spi_cs_n))
    else $error("clock fell without select");
  low_half_a: assert property ($fell(spi_sclk) |-> !spi_sclk [*4] ##1 spi_sclk)
    else $error("bad low half");
  high_half_a: assert property ($rose(spi_sclk) && !spi_cs_n |-> spi_sclk [*4])
    else $error("bad high half");
  mosi_fall_a: assert property (
    !spi_cs_n && !$past(spi_cs_n) && spi_mosi_oe && $past(spi_mosi_oe) && $changed(spi_mosi)
    |-> $fell(spi_sclk)) else $error("data moved off a fall");
  byte_count_a: assert property ($rose(spi_cs_n) |-> rise_cnt_q == 3'h0)
    else $error("select rose mid-byte");
  oe_drop_a: assert property ($fell(spi_mosi_oe) |-> !spi_cs_n ##1 $fell(spi_sclk))
    else $error("release off a data fall");
  start_frame_a: assert property (
    go && !bc_rd && spi_cs_n && $past(spi_cs_n, 5) |=> !spi_cs_n ##5 $fell(spi_sclk))
    else $error("frame start late");
  bcast_read_a: assert property (
    go && bc_rd && spi_cs_n && $past(spi_cs_n, 5) |=> spi_cs_n [*8])
    else $error("broadcast read sent");
endmodule
bind spi_daisy_host spi_daisy_host_chk #(.HALF_CYC(HALF_CYC)) u_chk
(
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_sclk(spi_sclk),
  .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_mosi_oe(spi_mosi_oe), .spi_miso(spi_miso)
);

// *** tb/spi_dev_model.sv ***
// Behavioural two-channel device at the head of the serial chain
`timescale 1ns/100ps
module spi_dev_model
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic [7:0] last_ctl,
  output logic bad
);
  logic [7:0] regs [2][128];
  logic [15:0] ram [2][128];
  logic [15:0] rbuf [2] = '{16'h0, 16'h0};
  logic [15:0] sh;
  logic [7:0] sr, hi;
  logic [6:0] addr;
  logic [3:0] channel_id;
  logic [2:0] bc = 3'h0;
  logic [1:0] idx = 2'h0;
  logic bcast, rd, isreg, hit, ch, ob;
  logic drv = 1'b0;
  initial bad = 1'b0;
  // head of chain, through pin grounded: output low when not driving
  assign sdo = drv && !cs_n ? ob : 1'b0;
  // Byte decode; flags protocol slips of the host
  task take_byte();
    case (idx)
      2'h0:
      begin
        {bcast, rd, isreg} = sr[7:5];
        channel_id = {sr[0], sr[1], sr[2], sr[3]};
        last_ctl = sr;
        bad = bad | sr[4] | (bcast & rd);
        hit = bcast || channel_id < 4'h2;
        ch = channel_id[0];
      end
      2'h1:
      begin
        addr = sr[6:0];
        bad = bad | sr[7];
        sh = isreg ? {2{regs[ch][addr]}} : rbuf[ch];
        drv = rd && hit;
      end
      2'h2:
      begin
        hi = sr;
        if (!rd && isreg && hit && (bcast || !ch))
          regs[0][addr] = sr;
        if (!rd && isreg && hit && (bcast || ch))
          regs[1][addr] = sr;
      end
      default:
      begin
        if (!isreg && hit && rd)
          rbuf[ch] = ram[ch][addr];
        if (!isreg && hit && !rd && (bcast || !ch))
          ram[0][addr] = {hi, sr};
        if (!isreg && hit && !rd && (bcast || ch))
          ram[1][addr] = {hi, sr};
      end
    endcase
    idx = idx + 2'h1;
    if (idx == 2'h0)
      drv = 1'b0;
  endtask
  always @(posedge sclk)
  begin
    if (!cs_n)
    begin
      sr = {sr[6:0], sdi};
      bc = bc + 3'h1;
      if (bc == 3'h0)
        take_byte();
    end
  end
  // rotate so a wide read repeats
  always @(negedge sclk)
  begin
    if (drv && !cs_n)
    begin
      ob = sh[15];
      sh = {sh[14:0], sh[15]};
    end
  end
  always @(posedge cs_n)
  begin
    if (bc != 3'h0 || (idx == 2'h3 && isreg))
    begin
      idx = 2'h0;
      drv = 1'b0;
    end
    bc = 3'h0;
  end
endmodule

// *** tb/spi_daisy_host_tb.sv ***
// Self-checking bench for the daisy-chain serial port controller
`timescale 1ns/100ps
module spi_daisy_host_tb
  import spi_host_pkg::*;
();
  typedef struct packed {logic [31:0] c; logic [6:0] a; logic [15:0] w, x;} row_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d, c;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_mosi_oe, spi_miso, bad;
  logic [7:0] last_ctl;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // Control word, address, write data, expected read
  row_t rows [10] = '{
    '{32'h004, 7'h05, 16'h00a5, 16'h0}, '{32'h006, 7'h05, 16'h0, 16'h00a5},
    '{32'h114, 7'h7f, 16'h003c, 16'h0}, '{32'h116, 7'h7f, 16'h0, 16'h003c},
    '{32'h000, 7'h10, 16'h1234, 16'h0}, '{32'h002, 7'h10, 16'h0, 16'h0},
    '{32'h012, 7'h10, 16'h0, 16'h1234}, '{32'h01c, 7'h03, 16'h0077, 16'h0},
    '{32'h106, 7'h03, 16'h0, 16'h0077}, '{32'h206, 7'h03, 16'h0, 16'h0}};
  always #10 clk_sys = ~clk_sys;
  spi_daisy_host u_dut
  (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_mosi_oe(spi_mosi_oe), .spi_miso(spi_miso)
  );
  // Released data line shows the inverse, never a held value
  spi_dev_model u_dev
  (
    .sclk(spi_sclk), .cs_n(spi_cs_n), .sdi(spi_mosi_oe ? spi_mosi : ~spi_mosi),
    .sdo(spi_miso), .last_ctl(last_ctl), .bad(bad)
  );
  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // Bus cycles; entered right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic start(input logic [31:0] k, input logic [6:0] a, input logic [15:0] w);
    wr(OFS_ADDR, {25'h0, a});
    wr(OFS_WDATA, {16'h0, w});
    wr(OFS_CTRL, k | 32'h1);
  endtask
  task automatic wait_done();
    d = 32'h0;
    for (int i = 0; i < 400 && d[STAT_DONE] !== 1'b1; i++)
      rd(OFS_STATUS);
    cmp(d & 32'h3, 32'h2);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Reset, table of transfers, then awkward cases
  initial
  begin
    repeat (20) @(posedge clk_sys);
    cmp({reg_rdata[27:0], spi_sclk, spi_cs_n, spi_mosi, spi_mosi_oe}, 32'hd);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i])
    begin
      c = rows[i].c;
      start(c, rows[i].a, rows[i].w);
      wait_done();
      cmp({24'h0, last_ctl}, {24'h0, c[3], c[1], c[2], 1'b0, c[8], c[9], c[10], c[11]});
      if (c[CTRL_READ])
      begin
        rd(OFS_RDATA);
        cmp(d & 32'hffff, {16'h0, rows[i].x});
      end
    end
    // Data written while busy must not reach the frame
    start(32'h004, 7'h06, 16'h0011);
    wr(OFS_WDATA, 32'h99);
    rd(OFS_STATUS);
    cmp(d & 32'h3, 32'h1);
    wait_done();
    start(32'h006, 7'h06, 16'h0);
    wait_done();
    rd(OFS_RDATA);
    cmp(d & 32'hffff, 32'h11);
    wr(OFS_CTRL, 32'h0f);
    repeat (8) @(posedge clk_sys);
    cmp({31'h0, spi_cs_n}, 32'h1);
    rd(OFS_STATUS);
    cmp(d & 32'h4, 32'h4);
    wr(OFS_STATUS, 32'h4);
    rd(OFS_STATUS);
    cmp(d & 32'h4, 32'h0);
    rd(8'h14);
    cmp(d, 32'h0);
    cmp({31'h0, bad}, 32'h0);
    report_and_stop();
  end
endmodule
